// ---- common/stop_ctl_pkg.sv ----
// Package for the stop-mode power controller: constants, types and carriers
package stop_ctl_pkg;

    // ========================================================================
    // Stop states
    typedef enum logic [2:0] {
        ST_RUN        = 3'b000,
        ST_HALT       = 3'b001,
        ST_PARTIAL    = 3'b010,
        ST_FULL       = 3'b011,
        ST_WAKE_RESET = 3'b100,
        ST_WAKE_IRQ   = 3'b101
    } stop_state_e;

    // ========================================================================
    // Wake vector selection
    typedef enum logic [1:0] {
        VEC_NONE     = 2'b00,
        VEC_RESET    = 2'b01,
        VEC_PIN_IRQ  = 2'b10,
        VEC_PERIODIC = 2'b11
    } wake_vec_e;

    // ========================================================================
    // Counts and field values
    localparam logic [2:0] PERIODIC_OFF    = 3'h0;
    localparam int         CLK_SYS_HZ      = 10_000_000;
    localparam int         PERIODIC_HZ     = 1_000;
    localparam int         PERIODIC_CYCLES = CLK_SYS_HZ / PERIODIC_HZ;
    localparam int         WAKE_PULSE_CYC  = 1;

    // ========================================================================
    // Stop configuration captured at STOP execution
    typedef struct packed {
        logic       power_down_ctl;
        logic       partial_power_down_ctl;
        logic       low_volt_reset_en;
        logic       debug_mode_en;
        logic       stop_allow;
        logic [2:0] periodic_wake_select;
    } stop_cfg_s;

    // Power and clock gating outputs
    typedef struct packed {
        logic osc_on;
        logic regulator_full;
        logic debug_clk_on;
        logic periph_clk_on;
        logic comparator_standby;
        logic pin_latch_closed;
        logic pins_forced_reset;
        logic ram_retained;
    } power_ctl_s;

endpackage : stop_ctl_pkg

// ---- logic/periodic_wake_timer.sv ----
// Self-clocked periodic wakeup source, modelled as a divided tick
`timescale 1ns/1ps
module periodic_wake_timer
    import stop_ctl_pkg::*;
#(
    parameter int PERIOD = PERIODIC_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [2:0] select,
    output logic            tick
);
    localparam int CW = $clog2(PERIOD + 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          next_tick;

    // ========================================================================
    // Divider; select of zero holds the source off entirely
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (!run || select == PERIODIC_OFF) begin
            next_count = '0;
        end else if (count == CW'(PERIOD - 1)) begin
            next_count = '0;
            next_tick  = 1'b1;
        end else begin
            next_count = count + CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

    chk_tick_off_zero: assert property (@(posedge clk_sys) disable iff (rst)
        $past(select) == PERIODIC_OFF |-> !tick)
        else $error("periodic tick while source disabled");
endmodule : periodic_wake_timer

// ---- logic/stop_mode_power_controller.sv ----
// Stop-mode selection, wakeup and pin-latch control for the microcontroller core
// Function
// - STOP with both power-down bits set enters partial-power-down state.
// - Partial-power-down never entered while low-voltage reset enabled.
// - Pin latch closes on partial entry, opens only on release ack.
// - Partial exit by reset pin, enabled pin irq or periodic wake.
// - Wake pins treated active-low in partial state regardless of polarity.
// - Partial wake behaves as power-on reset; pin latches stay closed.
// - Partial flag set after wake until release ack written.
// - Clock-halt stops all clocks unless debug or low-voltage reset enabled; state retained, pins driven by logic.
// - Halt exit: reset pin gives reset vector, interrupt gives its vector.
// - Periodic source wakes from halt or partial stop, not full; select zero disables it.
// - Debug enabled keeps debug clocks and full regulation in stop.
// - Debug enabled forces clock-halt state with oscillator and regulator on.
// - Memory-with-status debug commands return stop error status in stop.
// - Debug BACKGROUND command in stop wakes into active background.
// - Low-voltage reset enabled keeps regulator on, power-down becomes halt.
// - Peripheral clocks halt in every stop state.
// - Full power-down forces pins to reset; wake resets registers, loses RAM.
// - Power-down wake resets timer, comparator, serial and carrier modules.
// - Keypad pins interrupt in halt, only active-low wake in power-down.
// - Analog comparator in standby in any stop state.
// - STOP with stop_allow clear forces illegal-opcode reset instead.
// - Full power-down with partial bit clear; halt with power-down clear.
`timescale 1ns/1ps
module stop_mode_power_controller
    import stop_ctl_pkg::*;
#(
    parameter int PERIOD = PERIODIC_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       stop_exec,
    input  wire stop_cfg_s  cfg,
    input  wire logic       pin_latch_release_ack,
    input  wire logic       reset_pin_n,
    input  wire logic       ext_irq_pin,
    input  wire logic       ext_irq_en,
    input  wire logic       ext_irq_pol_high,
    input  wire logic       keypad_irq,
    input  wire logic       keypad_irq_en,
    input  wire logic       keypad_pol_high,
    input  wire logic       dbg_mem_status_cmd,
    input  wire logic       dbg_background_cmd,
    output stop_state_e     state,
    output power_ctl_s      power,
    output logic            partial_power_down_flag,
    output logic            illegal_opcode_reset,
    output logic            por_reset,
    output logic            periph_reset,
    output logic            ram_lost,
    output wake_vec_e       wake_vector,
    output logic            keypad_irq_out,
    output logic            dbg_stop_error,
    output logic            dbg_enter_background
);

    // ========================================================================
    // Pin synchronisers (two flops, first flop read only by the second)
    logic [2:0] sync1;
    logic [2:0] sync2;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
        end else begin
            sync1 <= {reset_pin_n, ext_irq_pin, keypad_irq};
            sync2 <= sync1;
        end
    end

    logic rst_pin_low;
    logic ext_s;
    logic kbd_s;
    assign rst_pin_low = !sync2[2];
    assign ext_s       = sync2[1];
    assign kbd_s       = sync2[0];

    // Asserted level of a pin under its configured polarity
    function automatic logic pin_active(input logic lvl, input logic pol_high);
        pin_active = pol_high ? lvl : !lvl;
    endfunction : pin_active

    // ========================================================================
    // Periodic wake source runs only while in a retaining stop state
    stop_cfg_s cfg_held;
    logic periodic_tick;
    logic periodic_run;
    assign periodic_run = (state == ST_HALT) || (state == ST_PARTIAL);

    periodic_wake_timer #(
        .PERIOD (PERIOD)
    ) u_periodic (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (periodic_run),
        .select  (cfg_held.periodic_wake_select),
        .tick    (periodic_tick)
    );

    // ========================================================================
    // State machine and captured configuration
    stop_cfg_s   next_cfg_held;
    stop_state_e next_state;
    logic        next_flag;
    logic        next_latch;
    logic        next_illegal;
    logic        next_por;
    logic        next_periph_rst;
    logic        next_ram_lost;
    wake_vec_e   next_vector;
    logic        next_dbg_err;
    logic        next_dbg_bg;
    logic        pin_wake_pd;
    logic        pin_irq_halt;
    logic        periodic_wake;

    // Power-down wake pins are forced active-low; halt uses configured polarity
    assign pin_wake_pd  = (ext_irq_en && !ext_s) || (keypad_irq_en && !kbd_s);
    assign pin_irq_halt = (ext_irq_en && pin_active(ext_s, ext_irq_pol_high))
                       || (keypad_irq_en && pin_active(kbd_s, keypad_pol_high));
    assign periodic_wake = periodic_tick && cfg_held.periodic_wake_select != PERIODIC_OFF;

    always_comb begin
        next_state      = state;
        next_cfg_held   = cfg_held;
        next_flag       = partial_power_down_flag;
        next_latch      = power.pin_latch_closed;
        next_illegal    = 1'b0;
        next_por        = 1'b0;
        next_periph_rst = 1'b0;
        next_ram_lost   = 1'b0;
        next_vector     = VEC_NONE;
        next_dbg_err    = 1'b0;
        next_dbg_bg     = 1'b0;
        // Ack opens latches and clears flag; a set on the same cycle wins
        if (pin_latch_release_ack && state == ST_RUN) begin
            next_flag  = 1'b0;
            next_latch = 1'b0;
        end
        case (state)
            ST_RUN: begin
                if (stop_exec) begin
                    next_cfg_held = cfg;
                    if (!cfg.stop_allow) begin
                        next_illegal = 1'b1;
                    end else if (cfg.debug_mode_en || cfg.low_volt_reset_en) begin
                        next_state = ST_HALT;
                    end else if (!cfg.power_down_ctl) begin
                        next_state = ST_HALT;
                    end else if (cfg.partial_power_down_ctl) begin
                        next_state = ST_PARTIAL;
                        next_latch = 1'b1;
                    end else begin
                        next_state = ST_FULL;
                    end
                end
            end
            ST_HALT: begin
                if (rst_pin_low) begin
                    next_state  = ST_WAKE_RESET;
                    next_vector = VEC_RESET;
                    next_por    = 1'b1;
                end else if (cfg_held.debug_mode_en && dbg_background_cmd) begin
                    next_state  = ST_RUN;
                    next_dbg_bg = 1'b1;
                end else if (pin_irq_halt) begin
                    next_state  = ST_WAKE_IRQ;
                    next_vector = VEC_PIN_IRQ;
                end else if (periodic_wake) begin
                    next_state  = ST_WAKE_IRQ;
                    next_vector = VEC_PERIODIC;
                end
                next_dbg_err = dbg_mem_status_cmd;
            end
            ST_PARTIAL, ST_FULL: begin
                if (rst_pin_low || pin_wake_pd
                    || (state == ST_PARTIAL && periodic_wake)) begin
                    next_state      = ST_WAKE_RESET;
                    next_vector     = VEC_RESET;
                    next_por        = 1'b1;
                    next_periph_rst = 1'b1;
                    next_ram_lost   = (state == ST_FULL);
                    next_flag       = (state == ST_PARTIAL) || partial_power_down_flag;
                end
                next_dbg_err = dbg_mem_status_cmd;
            end
            ST_WAKE_RESET, ST_WAKE_IRQ: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state                   <= ST_RUN;
            cfg_held                <= '0;
            partial_power_down_flag <= 1'b0;
            illegal_opcode_reset    <= 1'b0;
            por_reset               <= 1'b0;
            periph_reset            <= 1'b0;
            ram_lost                <= 1'b0;
            wake_vector             <= VEC_NONE;
            dbg_stop_error          <= 1'b0;
            dbg_enter_background    <= 1'b0;
        end else begin
            state                   <= next_state;
            cfg_held                <= next_cfg_held;
            partial_power_down_flag <= next_flag;
            illegal_opcode_reset    <= next_illegal;
            por_reset               <= next_por;
            periph_reset            <= next_periph_rst;
            ram_lost                <= next_ram_lost;
            wake_vector             <= next_vector;
            dbg_stop_error          <= next_dbg_err;
            dbg_enter_background    <= next_dbg_bg;
        end
    end

    // ========================================================================
    // Power and clock gating, registered from the next state
    power_ctl_s next_power;
    logic       next_kbd_out;
    logic       stopping;

    always_comb begin
        stopping  = next_state inside {ST_HALT, ST_PARTIAL, ST_FULL};
        next_power                  = power;
        next_power.pin_latch_closed = next_latch;
        next_power.periph_clk_on    = !stopping;
        next_power.comparator_standby = stopping;
        next_power.osc_on = !stopping || cfg_held_next_dbg(next_cfg_held, stopping);
        next_power.regulator_full = !stopping
            || next_cfg_held.debug_mode_en || next_cfg_held.low_volt_reset_en;
        next_power.debug_clk_on = !stopping || next_cfg_held.debug_mode_en;
        next_power.pins_forced_reset = (next_state == ST_FULL);
        next_power.ram_retained = (next_state != ST_FULL);
        next_kbd_out = (state == ST_HALT || state == ST_RUN) && keypad_irq_en
                       && pin_active(kbd_s, keypad_pol_high);
    end

    // Oscillator stays on in stop only while debug or low-voltage reset holds it
    function automatic logic cfg_held_next_dbg(input stop_cfg_s c, input logic s);
        cfg_held_next_dbg = s && (c.debug_mode_en || c.low_volt_reset_en);
    endfunction : cfg_held_next_dbg

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            power.osc_on             <= 1'b1;
            power.regulator_full     <= 1'b1;
            power.debug_clk_on       <= 1'b1;
            power.periph_clk_on      <= 1'b1;
            power.comparator_standby <= 1'b0;
            power.pin_latch_closed   <= 1'b0;
            power.pins_forced_reset  <= 1'b0;
            power.ram_retained       <= 1'b1;
            keypad_irq_out           <= 1'b0;
        end else begin
            power.osc_on             <= next_power.osc_on;
            power.regulator_full     <= next_power.regulator_full;
            power.debug_clk_on       <= next_power.debug_clk_on;
            power.periph_clk_on      <= next_power.periph_clk_on;
            power.comparator_standby <= next_power.comparator_standby;
            power.pin_latch_closed   <= next_power.pin_latch_closed;
            power.pins_forced_reset  <= next_power.pins_forced_reset;
            power.ram_retained       <= next_power.ram_retained;
            keypad_irq_out           <= next_kbd_out;
        end
    end

    // ========================================================================
    // Checks
    chk_partial_entry_ok: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_RUN && stop_exec && cfg.stop_allow && cfg.power_down_ctl
        && cfg.partial_power_down_ctl && !cfg.debug_mode_en && !cfg.low_volt_reset_en
        |=> state == ST_PARTIAL && power.pin_latch_closed)
        else $error("partial stop not entered");

    chk_partial_lvr_block: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(state == ST_PARTIAL) |-> !cfg_held.low_volt_reset_en
        && !cfg_held.debug_mode_en)
        else $error("partial stop with override set");

    chk_latch_held_ack: assert property (@(posedge clk_sys) disable iff (rst)
        power.pin_latch_closed && !(state == ST_RUN && pin_latch_release_ack)
        |=> power.pin_latch_closed)
        else $error("pin latch opened without ack");

    chk_flag_after_wake: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_PARTIAL && next_state == ST_WAKE_RESET
        |=> partial_power_down_flag && por_reset ##1 state == ST_RUN)
        else $error("partial wake flag missing");

    chk_illegal_stop: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_RUN && stop_exec && !cfg.stop_allow
        |=> illegal_opcode_reset && state == ST_RUN)
        else $error("illegal stop not trapped");

    chk_periph_clk_halt: assert property (@(posedge clk_sys) disable iff (rst)
        state inside {ST_HALT, ST_PARTIAL, ST_FULL} |-> !power.periph_clk_on
        && power.comparator_standby)
        else $error("peripheral clock running in stop");

    chk_debug_halt_only: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_RUN && stop_exec && cfg.stop_allow && cfg.debug_mode_en
        |=> state == ST_HALT ##0 power.osc_on && power.regulator_full)
        else $error("debug stop not clock-halt");

    chk_full_pins_reset: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_FULL |-> power.pins_forced_reset && !power.ram_retained)
        else $error("full power-down pins not reset");

    chk_halt_reset_vec: assert property (@(posedge clk_sys) disable iff (rst)
        state == ST_HALT && rst_pin_low |=> wake_vector == VEC_RESET && por_reset)
        else $error("halt reset exit wrong vector");

    chk_dbg_status_err: assert property (@(posedge clk_sys) disable iff (rst)
        state != ST_RUN && state != ST_WAKE_RESET && state != ST_WAKE_IRQ
        && dbg_mem_status_cmd |=> dbg_stop_error)
        else $error("no stop error on debug status command");

endmodule : stop_mode_power_controller

// ---- testbench/tb.sv ----
// Self-checking bench for the stop-mode power controller
`timescale 1ns/1ps
module tb;
    import stop_ctl_pkg::*;
    // ========================================================================
    // Stimulus and observed signals
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        stop_exec = 1'b0;
    stop_cfg_s   cfg     = '0;
    logic        ack     = 1'b0;
    logic        ext_en  = 1'b1, ext_pol = 1'b1, key_en = 1'b1, key_pol = 1'b1;
    logic        mem_cmd = 1'b0, bg_cmd = 1'b0, clr = 1'b0;
    logic [2:0]  fire    = 3'h0;
    logic        reset_pin_n, ext_irq_pin, keypad_irq;
    stop_state_e state;
    power_ctl_s  power;
    wake_vec_e   wake_vector;
    logic        flag, illegal, por, prst, ram_lost, kout, derr, dbg_bg;
    logic [7:0]  seen    = 8'h00;
    int          n_mismatch = 0;
    int          n_checks   = 0;

    always #50 clk_sys = ~clk_sys;

    // Sticky capture, since one-cycle pulses are easy to miss between checks
    always @(posedge clk_sys) begin
        seen <= clr ? 8'h00 : seen | {1'b0, kout, illegal, derr, dbg_bg, ram_lost, prst, por};
    end

    wake_pin_model u_pins (.clk_sys(clk_sys), .fire(fire), .reset_pin_n(reset_pin_n),
        .ext_irq_pin(ext_irq_pin), .keypad_irq(keypad_irq));

    // Short periodic count keeps the run brief
    stop_mode_power_controller #(.PERIOD(8)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .stop_exec(stop_exec), .cfg(cfg),
        .pin_latch_release_ack(ack), .reset_pin_n(reset_pin_n), .ext_irq_pin(ext_irq_pin),
        .ext_irq_en(ext_en), .ext_irq_pol_high(ext_pol), .keypad_irq(keypad_irq),
        .keypad_irq_en(key_en), .keypad_pol_high(key_pol), .dbg_mem_status_cmd(mem_cmd),
        .dbg_background_cmd(bg_cmd), .state(state), .power(power),
        .partial_power_down_flag(flag), .illegal_opcode_reset(illegal), .por_reset(por),
        .periph_reset(prst), .ram_lost(ram_lost), .wake_vector(wake_vector),
        .keypad_irq_out(kout), .dbg_stop_error(derr), .dbg_enter_background(dbg_bg));

    // ========================================================================
    // Shared tasks
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait; a hang ends the run
    task wait_state(input stop_state_e t);
        int i;
        for (i = 0; i < 60 && state !== t; i++) @(negedge clk_sys);
        if (state !== t) begin
            n_mismatch++;
            $display("[ERR] %0t state wait expired", $time);
            final_report();
        end
    endtask : wait_state

    // Config byte: pd, ppd, lvr, dbg, allow, select[2:0]
    task do_stop(input logic [7:0] c);
        @(negedge clk_sys);
        cfg = stop_cfg_s'(c);
        stop_exec = 1'b1;
        clr = 1'b1;
        @(negedge clk_sys);
        stop_exec = 1'b0;
        clr = 1'b0;
        @(negedge clk_sys);
    endtask : do_stop

    // Fire pins (reset, ext, keypad) then expect the wake state and vector
    task wake(input logic [2:0] f, input stop_state_e t, input wake_vec_e v);
        if (f !== 3'h0) begin
            @(negedge clk_sys);
            fire = f;
            @(negedge clk_sys);
            fire = 3'h0;
        end
        wait_state(t);
        chk({6'h0, wake_vector}, {6'h0, v});
    endtask : wake

    // ========================================================================
    // Main sequence
    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(power, 8'hf1);
        // Partial power-down, wake pin configured high yet woken by a low level
        do_stop(8'hc8);
        chk({5'h0, state}, {5'h0, ST_PARTIAL});
        chk(power, 8'h0d);
        wake(3'h2, ST_WAKE_RESET, VEC_RESET);
        chk({7'h0, flag}, 8'h01);
        repeat (3) @(negedge clk_sys);
        chk(seen & 8'h3f, 8'h03);
        chk(power, 8'hf5);
        @(negedge clk_sys);
        ack = 1'b1;
        @(negedge clk_sys);
        ack = 1'b0;
        @(negedge clk_sys);
        chk({7'h0, flag}, 8'h00);
        chk(power, 8'hf1);
        // Full power-down, keypad wake
        do_stop(8'h88);
        chk({5'h0, state}, {5'h0, ST_FULL});
        chk(power, 8'h0a);
        wake(3'h1, ST_WAKE_RESET, VEC_RESET);
        repeat (3) @(negedge clk_sys);
        chk(seen & 8'h3f, 8'h07);
        // Clock-halt cases use the configured polarity
        ext_pol = 1'b0;
        key_pol = 1'b0;
        do_stop(8'he8);
        chk({5'h0, state}, {5'h0, ST_HALT});
        chk(power & 8'h7f, 8'h49);
        wake(3'h2, ST_WAKE_IRQ, VEC_PIN_IRQ);
        repeat (2) @(negedge clk_sys);
        chk(seen & 8'h3f, 8'h00);
        do_stop(8'h09);
        chk(power, 8'h09);
        wake(3'h0, ST_WAKE_IRQ, VEC_PERIODIC);
        do_stop(8'h08);
        repeat (40) @(negedge clk_sys);
        chk({5'h0, state}, {5'h0, ST_HALT});
        wake(3'h4, ST_WAKE_RESET, VEC_RESET);
        repeat (8) @(negedge clk_sys);
        chk(seen & 8'h01, 8'h01);
        do_stop(8'h08);
        wake(3'h1, ST_WAKE_IRQ, VEC_PIN_IRQ);
        // The halt-time keypad pulse reaches the sticky capture one edge later
        @(negedge clk_sys);
        chk(seen & 8'h40, 8'h40);
        repeat (6) @(negedge clk_sys);
        // Debug enabled overrides both power-down bits
        do_stop(8'hd8);
        chk({5'h0, state}, {5'h0, ST_HALT});
        chk(power, 8'he9);
        mem_cmd = 1'b1;
        @(negedge clk_sys);
        mem_cmd = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(seen & 8'h3f, 8'h10);
        bg_cmd = 1'b1;
        @(negedge clk_sys);
        bg_cmd = 1'b0;
        wait_state(ST_RUN);
        repeat (2) @(negedge clk_sys);
        chk(seen & 8'h08, 8'h08);
        // Stop not allowed
        do_stop(8'hc0);
        chk({5'h0, state}, {5'h0, ST_RUN});
        chk(seen & 8'h3f, 8'h20);
        final_report();
    end
endmodule : tb

// ---- testbench/wake_pin_model.sv ----
// Model of the wakeup pins that face the controller: reset, external irq and keypad
`timescale 1ns/1ps
module wake_pin_model #(
    parameter int HOLD = 4
) (
    input  wire logic       clk_sys,
    input  wire logic [2:0] fire,
    output logic            reset_pin_n,
    output logic            ext_irq_pin,
    output logic            keypad_irq
);
    // ========================================================================
    // Hold counters, one per pin
    int cnt [3] = '{0, 0, 0};

    // A request pulls the pin low long enough to cross a two-flop synchroniser
    always @(posedge clk_sys) begin
        for (int k = 0; k < 3; k++) begin
            if (fire[k]) begin
                cnt[k] <= HOLD;
            end else if (cnt[k] > 0) begin
                cnt[k] <= cnt[k] - 1;
            end
        end
    end

    // Released pins sit at their pull-up level; a wake is always driven low
    assign keypad_irq  = !(cnt[0] > 0);
    assign ext_irq_pin = !(cnt[1] > 0);
    assign reset_pin_n = !(cnt[2] > 0);
endmodule : wake_pin_model
